//--- drs_shifter.sv
// Dual accumulator shift unit with an Avalon-MM register slave.
//
// Contract
// RULE1 - Shift count comes from operand bits 15 to 23 for every shift.
// RULE2 - Arithmetic right double keeps high sign, high bit 23 enters low bit 0.
// RULE3 - Arithmetic right twin extends each sign separately, no bit crosses registers.
// RULE4 - Logical right single moves sign, fills zeros, drops bits past 23.
// RULE5 - Logical right double zero-fills high, high bit 23 enters low bit 0.
// RULE6 - Logical right twin zero-fills both, high bit 23 is discarded.
// RULE7 - Circular right single feeds bit 23 back into bit 0.
// RULE8 - Circular right double rotates the 48-bit pair, nothing lost.
// RULE9 - Circular right twin rotates each register onto itself.
// RULE10 - Arithmetic left single sets overflow when the sign position changes.
// RULE11 - Arithmetic left double moves low bit 0 into high 23, checks high sign.
// RULE12 - Arithmetic left twin checks only the high sign, no crossing bits.
// RULE13 - Logical left single moves sign, zero-fills right end, drops bits.
// RULE14 - Logical left double moves low bit 0 into high bit 23, zero-fills.
// RULE15 - Right shifts take 2 to 7 memory cycles; singles touch one register.
// RULE16 - Zero count shifts nothing; counts above 48 clamp to 48, decrement per step.
// RULE17 - Operand bits 10 and 11 select double, low, high or twin.
// RULE18 - Operand bit 12 gives direction, 13 shift or cycle, 14 arithmetic or logical.
// RULE19 - Operand bit 9 set asks for normalize, not an ordinary shift.
// RULE20 - Overflow is only ever set, and only by arithmetic left shifts; here a status write with bit 1 set also clears it.
//
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module drs_shifter
  import drs_pkg::*;
(
  // Clock and reset.
  input  wire logic              clock,
  input  wire logic              rst_n,
  // Avalon-MM slave.
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [3:0]        byteenable,
  input  wire logic [BUS_W-1:0]  writedata,
  output logic      [BUS_W-1:0]  readdata,
  output logic                   waitrequest,
  // Status seen by the sequencer.
  output logic                   busy,
  output logic                   overflow_flag
);

  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } drs_state_t;

  drs_state_t          state_r;
  drs_state_t          state_nxt;
  logic [WORD_W-1:0]   high_word_r;
  logic [WORD_W-1:0]   high_word_nxt;
  logic [WORD_W-1:0]   low_word_r;
  logic [WORD_W-1:0]   low_word_nxt;
  logic [WORD_W-1:0]   operand_r;
  logic [WORD_W-1:0]   operand_nxt;
  logic [COUNT_W-1:0]  count_r;
  logic [COUNT_W-1:0]  count_nxt;
  logic [TIMER_W-1:0]  timer_r;
  logic [TIMER_W-1:0]  timer_nxt;
  logic                sign_r;
  logic                sign_nxt;
  logic                ovf_r;
  logic                ovf_nxt;
  logic                norm_r;
  logic                norm_nxt;
  logic                waitreq_r;
  logic                waitreq_nxt;
  logic [BUS_W-1:0]    rdata_r;
  logic [BUS_W-1:0]    rdata_nxt;
  logic                busy_r;

  // Decoded command, taken from the stored operand while running.
  wire drs_cmd_t           cmd;
  wire drs_cmd_t           new_cmd;
  wire logic               is_double;
  wire logic               upd_high;
  wire logic               upd_low;
  wire logic               arith;
  wire logic               arith_left;
  wire drs_step_t          high_ctl;
  wire drs_step_t          low_ctl;
  wire logic [WORD_W-1:0]  high_step;
  wire logic [WORD_W-1:0]  low_step;
  wire logic               high_out;
  wire logic               low_out;
  wire logic               stepping;
  wire logic               check_high;
  wire logic               check_low;
  wire logic               sign_upset;

  // Bus decode.
  wire logic               req;
  wire logic               fire;
  wire logic               wr_fire;
  wire logic               wr_high;
  wire logic               wr_low;
  wire logic               wr_cmd;
  wire logic               wr_stat;
  wire logic               start;
  wire logic [BUS_W-1:0]   be_mask;
  wire logic [BUS_W-1:0]   status_word;
  wire logic [BUS_W-1:0]   read_mux;
  wire logic [COUNT_W-1:0] clamp_count;
  wire logic [TIMER_W-1:0] run_clocks;

  assign cmd     = drs_cmd_t'(operand_r[14:0]);                          // [RULE18]
  assign new_cmd = drs_cmd_t'(writedata[14:0]);

  // Register selection and mode.
  assign is_double  = (cmd.sel == SEL_DOUBLE);                           // [RULE17]
  assign upd_high   = (cmd.sel != SEL_LOW);                              // [RULE15]
  assign upd_low    = (cmd.sel != SEL_HIGH);                             // [RULE15]
  assign arith      = !cmd.logical && !cmd.cycle;
  assign arith_left = arith && cmd.left;

  // High word: double pair takes the low word's outgoing bit on left or circular steps, others rotate or fill.
  assign high_ctl.left      = cmd.left;
  assign high_ctl.keep_sign = arith && !cmd.left;                        // [RULE2] [RULE3]
  assign high_ctl.in_bit    = (cmd.left && is_double) ? low_out :        // [RULE11] [RULE14]
                              cmd.cycle ? (is_double ? low_out : high_out) : // [RULE7] [RULE8]
                              1'b0;                                      // [RULE4] [RULE13]

  // Low word: only a double pair chains bits in from the high word.
  assign low_ctl.left      = cmd.left;
  assign low_ctl.keep_sign = arith && !cmd.left && !is_double;           // [RULE3]
  assign low_ctl.in_bit    = (!cmd.left && is_double && !cmd.cycle) ? high_out : // [RULE2] [RULE5]
                             cmd.cycle ? (is_double ? high_out : low_out) : // [RULE8] [RULE9]
                             1'b0;                                       // [RULE6] [RULE12]

  drs_step #(
    .W (WORD_W)
  ) u_high_step (
    .word     (high_word_r),
    .ctl      (high_ctl),
    .word_nxt (high_step),
    .out_bit  (high_out)
  );

  drs_step #(
    .W (WORD_W)
  ) u_low_step (
    .word     (low_word_r),
    .ctl      (low_ctl),
    .word_nxt (low_step),
    .out_bit  (low_out)
  );

  assign stepping = (state_r == ST_RUN) && (count_r != RESET_COUNT);    // [RULE16]

  // Only the sign of the high word is watched, except for a low-only shift.
  assign check_high = arith_left && upd_high;                            // [RULE10] [RULE11] [RULE12]
  assign check_low  = arith_left && (cmd.sel == SEL_LOW);                // [RULE10]
  assign sign_upset = stepping &&
                      ((check_high && (high_word_r[WORD_W-2] != sign_r)) ||
                       (check_low  && (low_word_r[WORD_W-2]  != sign_r))); // [RULE20]

  // Avalon access: waitrequest drops for one cycle on a request while the unit is idle.
  assign req     = read || write;
  assign fire    = req && !waitreq_r;
  assign wr_fire = write && !waitreq_r;
  assign wr_high = wr_fire && (address == ADDR_HIGH_WORD);
  assign wr_low  = wr_fire && (address == ADDR_LOW_WORD);
  assign wr_cmd  = wr_fire && (address == ADDR_COMMAND);
  assign wr_stat = wr_fire && (address == ADDR_STATUS);
  assign start   = wr_cmd && !new_cmd.normalize;                         // [RULE19]

  assign be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                    {8{byteenable[1]}}, {8{byteenable[0]}}};

  assign status_word = {29'h00000000, norm_r, ovf_r, busy_r};

  assign read_mux = (address == ADDR_HIGH_WORD) ? {8'h00, high_word_r} :
                    (address == ADDR_LOW_WORD)  ? {8'h00, low_word_r}  :
                    (address == ADDR_COMMAND)   ? {8'h00, operand_r}   :
                    (address == ADDR_STATUS)    ? status_word          :
                    RESET_BUS;

  // Count clamp, then the fixed run length in clocks for that count.
  assign clamp_count = (new_cmd.count > MAX_COUNT) ? MAX_COUNT : new_cmd.count; // [RULE1] [RULE16]
  assign run_clocks  = TIMER_W'(mem_cycles(new_cmd.left, clamp_count) * MEM_CYCLE_CLKS);

  // Memory cycles spent for a given clamped count.
  function automatic int unsigned mem_cycles(input logic left, input logic [COUNT_W-1:0] c);
    int unsigned n;
    n = 0;
    if (left)
    begin
      if (c <= LEFT_LIM_2)
        n = 2;
      else if (c <= LEFT_LIM_3)
        n = 3;
      else
        n = 4;
    end
    else
    begin
      if (c <= RIGHT_LIM_2)
        n = 2;
      else if (c <= RIGHT_LIM_3)
        n = 3;
      else if (c <= RIGHT_LIM_4)
        n = 4;
      else if (c <= RIGHT_LIM_5)
        n = 5;
      else if (c <= RIGHT_LIM_6)
        n = 6;
      else
        n = 7;
    end
    return n;
  endfunction : mem_cycles

  // Next-state logic of the shift sequence and the register file.
  always_comb
  begin
    state_nxt     = state_r;
    high_word_nxt = high_word_r;
    low_word_nxt  = low_word_r;
    operand_nxt   = operand_r;
    count_nxt     = count_r;
    timer_nxt     = timer_r;
    sign_nxt      = sign_r;
    ovf_nxt       = ovf_r;
    norm_nxt      = norm_r;
    case (state_r)
      ST_IDLE:
      begin
        if (wr_high)
          high_word_nxt = WORD_W'((writedata & be_mask) | ({8'h00, high_word_r} & ~be_mask));
        if (wr_low)
          low_word_nxt = WORD_W'((writedata & be_mask) | ({8'h00, low_word_r} & ~be_mask));
        if (wr_cmd)
        begin
          operand_nxt = writedata[WORD_W-1:0];
          norm_nxt    = new_cmd.normalize;                               // [RULE19]
        end
        if (start)
        begin
          state_nxt = ST_RUN;
          count_nxt = clamp_count;                                       // [RULE16]
          timer_nxt = run_clocks;                                        // [RULE15]
          // The original sign belongs to the word whose sign is watched.
          sign_nxt  = (new_cmd.sel == SEL_LOW) ? low_word_r[WORD_W-1]
                                               : high_word_r[WORD_W-1];
        end
        // Software may clear overflow only while idle; no shift can set it then.
        if (wr_stat && byteenable[0] && writedata[STAT_OVF_BIT])
          ovf_nxt = 1'b0;
      end
      ST_RUN:
      begin
        if (stepping)
        begin
          count_nxt = count_r - ONE_COUNT;                               // [RULE16]
          if (upd_high)
            high_word_nxt = high_step;                                   // [RULE15]
          if (upd_low)
            low_word_nxt = low_step;                                     // [RULE15]
        end
        if (sign_upset)
          ovf_nxt = 1'b1;                                                // [RULE20]
        timer_nxt = timer_r - 8'h01;
        if (timer_r == 8'h01)
          state_nxt = ST_IDLE;                                           // [RULE15]
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Bus answer: a request is held off while a shift is in progress.
  always_comb
  begin
    waitreq_nxt = !(req && waitreq_r && (state_r == ST_IDLE));
    rdata_nxt   = fire ? rdata_r : read_mux;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_r     <= ST_IDLE;
      high_word_r <= RESET_WORD;
      low_word_r  <= RESET_WORD;
      operand_r   <= RESET_WORD;
      count_r     <= RESET_COUNT;
      timer_r     <= RESET_TIMER;
      sign_r      <= 1'b0;
      ovf_r       <= 1'b0;
      norm_r      <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      high_word_r <= high_word_nxt;
      low_word_r  <= low_word_nxt;
      operand_r   <= operand_nxt;
      count_r     <= count_nxt;
      timer_r     <= timer_nxt;
      sign_r      <= sign_nxt;
      ovf_r       <= ovf_nxt;
      norm_r      <= norm_nxt;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      waitreq_r <= 1'b1;
      rdata_r   <= RESET_BUS;
      busy_r    <= 1'b0;
    end
    else
    begin
      waitreq_r <= waitreq_nxt;
      rdata_r   <= rdata_nxt;
      busy_r    <= (state_nxt == ST_RUN);
    end
  end

  assign readdata      = rdata_r;
  assign waitrequest   = waitreq_r;
  assign busy          = busy_r;
  assign overflow_flag = ovf_r;

endmodule : drs_shifter

//--- drs_pkg.sv
// Package with constants, types and register map of the dual register shifter.
package drs_pkg;

  // Data path widths.
  localparam int unsigned WORD_W   = 24;
  localparam int unsigned BUS_W    = 32;
  localparam int unsigned ADDR_W   = 3;
  localparam int unsigned COUNT_W  = 9;
  localparam int unsigned TIMER_W  = 8;

  // Register word addresses on the Avalon-MM slave.
  localparam logic [ADDR_W-1:0] ADDR_HIGH_WORD = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_LOW_WORD  = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_COMMAND   = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_STATUS    = 3'h3;

  // Status register field positions.
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_OVF_BIT  = 1;
  localparam int unsigned STAT_NORM_BIT = 2;

  // Values after reset.
  localparam logic [WORD_W-1:0]  RESET_WORD  = 24'h000000;
  localparam logic [BUS_W-1:0]   RESET_BUS   = 32'h00000000;
  localparam logic [COUNT_W-1:0] RESET_COUNT = 9'h000;
  localparam logic [TIMER_W-1:0] RESET_TIMER = 8'h00;

  // Shift count limit and per-step decrement.
  localparam logic [COUNT_W-1:0] MAX_COUNT = 9'h030;
  localparam logic [COUNT_W-1:0] ONE_COUNT = 9'h001;

  // Memory cycle expressed in processor clocks, rounded up as a least time.
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned MEM_CYCLE_NS   = 1750;
  localparam int unsigned MEM_CYCLE_CLKS = (MEM_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Count thresholds of the memory-cycle timing table.
  localparam int unsigned RIGHT_LIM_2 = 3;
  localparam int unsigned RIGHT_LIM_3 = 14;
  localparam int unsigned RIGHT_LIM_4 = 25;
  localparam int unsigned RIGHT_LIM_5 = 36;
  localparam int unsigned RIGHT_LIM_6 = 47;
  localparam int unsigned LEFT_LIM_2  = 6;
  localparam int unsigned LEFT_LIM_3  = 28;

  // Register selection codes, first operand bit of the pair on the left.
  typedef enum logic [1:0] {
    SEL_DOUBLE = 2'h0,
    SEL_LOW    = 2'h1,
    SEL_HIGH   = 2'h2,
    SEL_TWIN   = 2'h3
  } drs_sel_t;

  // Low 15 operand bits, in vector order; the sign end is the most significant.
  typedef struct packed {
    logic                normalize;
    drs_sel_t            sel;
    logic                left;
    logic                cycle;
    logic                logical;
    logic [COUNT_W-1:0]  count;
  } drs_cmd_t;

  // Per-register step controls handed to a step slice.
  typedef struct packed {
    logic  left;
    logic  keep_sign;
    logic  in_bit;
  } drs_step_t;

endpackage : drs_pkg

//--- drs_step.sv
// One-position shift step of a single accumulator word.
`timescale 1ns/1ps
module drs_step
  import drs_pkg::*;
#(
  parameter int unsigned W = WORD_W
)
(
  // Word and step controls.
  input  wire logic [W-1:0] word,
  input  wire drs_step_t    ctl,
  // Stepped word and the bit that left it.
  output logic      [W-1:0] word_nxt,
  output logic              out_bit
);

  wire logic [W-1:0] right_word;
  wire logic [W-1:0] left_word;

  // An arithmetic right step holds the sign and copies it downward.
  assign right_word = ctl.keep_sign ? {word[W-1], word[W-1:1]} : {ctl.in_bit, word[W-1:1]};
  assign left_word  = {word[W-2:0], ctl.in_bit};
  assign word_nxt   = ctl.left ? left_word : right_word;
  assign out_bit    = ctl.left ? word[W-1] : word[0];

endmodule : drs_step

//--- drs_shifter_assertions.sv
// Concurrent checks on the ports of the dual register shifter.
`timescale 1ns/1ps
module drs_shifter_assertions
  import drs_pkg::*;
(
  // Clock and reset.
  input wire logic              clock,
  input wire logic              rst_n,
  // Register bus.
  input wire logic [ADDR_W-1:0] address,
  input wire logic              read,
  input wire logic              write,
  input wire logic [3:0]        byteenable,
  input wire logic [BUS_W-1:0]  writedata,
  input wire logic [BUS_W-1:0]  readdata,
  input wire logic              waitrequest,
  // Status.
  input wire logic              busy,
  input wire logic              overflow_flag
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Counts the clocks of the current busy stretch so the run length can be judged.
  logic [7:0] blen_r;
  logic       cmd_w;
  logic       clr_w;
  assign cmd_w = write && !waitrequest && (address == ADDR_COMMAND) && (byteenable == 4'hF);
  assign clr_w = write && !waitrequest && (address == ADDR_STATUS) && writedata[STAT_OVF_BIT]
                 && byteenable[0];
  always_ff @(posedge clock)
    blen_r <= (busy && rst_n) ? blen_r + 8'h01 : 8'h00;

  a_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest stayed low for more than one cycle");
  a_wait_cause: assert property ($fell(waitrequest) |-> $past(read || write))
    else $error("waitrequest fell without a request");
  a_busy_stall: assert property (busy |-> waitrequest)
    else $error("access answered while a shift runs");
  a_cmd_start: assert property (cmd_w && !writedata[14] |=> busy)
    else $error("command write did not start a shift");
  a_norm_idle: assert property (cmd_w && writedata[14] |=> !busy)
    else $error("normalize request started a shift");
  a_run_length: assert property ($fell(busy) |-> (blen_r % MEM_CYCLE_CLKS == 0)
    && (blen_r >= 8'h24) && (blen_r <= 8'h7E))
    else $error("shift run length is not a whole count of memory cycles");
  a_ovf_sticky: assert property ($fell(overflow_flag) |-> $past(clr_w))
    else $error("overflow flag cleared without a status write");
  a_ovf_in_shift: assert property ($rose(overflow_flag) |-> $past(busy))
    else $error("overflow flag set outside a shift");
  a_unmapped_zero: assert property (read && !waitrequest && address[2]
    |-> readdata == 32'h00000000)
    else $error("unmapped read returned nonzero data");
endmodule : drs_shifter_assertions

bind drs_shifter drs_shifter_assertions drs_shifter_assertions_inst (
  .clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
  .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .busy(busy), .overflow_flag(overflow_flag)
);

//--- drs_seq_model.sv
// Sequencer model that issues register accesses as an Avalon-MM master.
`timescale 1ns/1ps
module drs_seq_model
  import drs_pkg::*;
(
  // Clock and reset.
  input  wire logic              clock,
  input  wire logic              rst_n,
  // Master side of the register bus.
  output logic      [ADDR_W-1:0] address    = 3'h0,
  output logic                   read       = 1'b0,
  output logic                   write      = 1'b0,
  output logic      [3:0]        byteenable = 4'h0,
  output logic      [BUS_W-1:0]  writedata  = 32'h00000000,
  input  wire logic [BUS_W-1:0]  readdata,
  input  wire logic              waitrequest
);
  // The request is held until waitrequest is sampled low; released lines show inverted
  // values so nothing can lean on stale address or data.
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [BUS_W-1:0] d, output logic [BUS_W-1:0] q);
    @(posedge clock);
    address    <= a;
    write      <= wr;
    read       <= !wr;
    writedata  <= d;
    byteenable <= 4'hF;
    do @(posedge clock); while (waitrequest !== 1'b0);
    q = readdata;
    read       <= 1'b0;
    write      <= 1'b0;
    address    <= ~a;
    writedata  <= ~d;
    byteenable <= 4'h0;
  endtask : access
endmodule : drs_seq_model

//--- drs_shifter_bench.sv
// Self-checking testbench of the dual register shifter.
`timescale 1ns/1ps
module drs_shifter_bench;
  import drs_pkg::*;
  logic              clock = 1'b0;
  logic              rst_n = 1'b0;
  logic [ADDR_W-1:0] address;
  logic              read;
  logic              write;
  logic [3:0]        byteenable;
  logic [BUS_W-1:0]  writedata;
  logic [BUS_W-1:0]  readdata;
  logic              waitrequest;
  logic              busy;
  logic              overflow_flag;
  logic [31:0]       x = 32'h22A9;
  logic [7:0]        blen;
  int                bad_count = 0;
  int                cmp_count = 0;
  int unsigned       corner [19] = '{0, 1, 3, 4, 14, 15, 25, 26, 36, 37, 47, 48, 49, 511, 6,
                                     7, 28, 29, 24};

  always #50 clock = ~clock;
  // Busy length of the latest shift; any accepted write restarts it.
  always @(posedge clock)
    if (busy === 1'b1) blen <= blen + 8'h01;
    else if (!waitrequest && write) blen <= 8'h00;

  drs_shifter drs_shifter_inst (.clock(clock), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .busy(busy), .overflow_flag(overflow_flag));
  drs_seq_model drs_seq_model_inst (.clock(clock), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest));

  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : rnd

  // One step of a single word: l left, c cycle, g logical.
  function automatic logic [23:0] ws(logic [23:0] w, logic l, logic c, logic g);
    return l ? {w[22:0], c & w[23]} : {c ? w[0] : (!g & w[23]), w[23:1]};
  endfunction : ws

  // Expected overflow, high word and low word after the whole shift.
  function automatic logic [48:0] model(logic [23:0] h, logic [23:0] b, drs_cmd_t k);
    logic [47:0] v;
    logic        o;
    logic        s;
    int          n;
    n = (k.count > 48) ? 48 : k.count;
    o = 1'b0;
    s = (k.sel == SEL_LOW) ? b[23] : h[23];
    for (int i = 0; i < n; i++)
    begin
      if (k.left && !k.cycle && !k.logical && (((k.sel == SEL_LOW) ? b[22] : h[22]) != s))
        o = 1'b1;
      v = {h, b};
      if (k.sel == SEL_DOUBLE)
        v = k.left ? {v[46:0], k.cycle & v[47]}
                   : {k.cycle ? v[0] : (!k.logical & v[47]), v[47:1]};
      else
      begin
        if (k.sel != SEL_LOW) v[47:24] = ws(h, k.left, k.cycle, k.logical);
        if (k.sel != SEL_HIGH) v[23:0] = ws(b, k.left, k.cycle, k.logical);
      end
      h = v[47:24];
      b = v[23:0];
    end
    return {o, h, b};
  endfunction : model

  // Memory cycles of the run for a clamped count.
  function automatic int mcyc(int c, logic l);
    if (l) return (c <= 6) ? 2 : (c <= 28) ? 3 : 4;
    return (c <= 3) ? 2 : (c <= 14) ? 3 : (c <= 25) ? 4 : (c <= 36) ? 5 : (c <= 47) ? 6 : 7;
  endfunction : mcyc

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic conclude();
    if (bad_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  initial
  begin
    // About 150 clocks per shift scenario; the margin covers a stalled bus.
    repeat (30000) @(posedge clock);
    bad_count++;
    conclude();
  end

  initial
  begin
    logic [31:0] q;
    logic [23:0] h;
    logic [23:0] b;
    logic [48:0] e;
    drs_cmd_t    k;
    int          c;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    for (int a = 0; a < 6; a++)
    begin
      drs_seq_model_inst.access(1'b0, a[2:0], 32'h00000000, q);
      chk("reset value", 32'h00000000, q);
    end
    for (int i = 0; i < 80; i++)
    begin
      h = i[5] ? 24'h000003 : rnd();
      b = rnd();
      c = (i < 19) ? corner[i] : rnd() % 512;
      k = drs_cmd_t'({1'b0, i[4:0], c[8:0]});
      e = model(h, b, k);
      drs_seq_model_inst.access(1'b1, ADDR_HIGH_WORD, {8'h00, h}, q);
      drs_seq_model_inst.access(1'b1, ADDR_LOW_WORD, {8'h00, b}, q);
      drs_seq_model_inst.access(1'b1, ADDR_COMMAND, {17'h00000, k}, q);
      drs_seq_model_inst.access(1'b0, ADDR_STATUS, 32'h00000000, q);
      chk("status", {30'h0, e[48], 1'b0}, {30'h0, q[1:0]});
      chk("run length", MEM_CYCLE_CLKS * mcyc((c > 48) ? 48 : c, k.left), blen);
      chk("overflow_flag", {31'h0, e[48]}, {31'h0, overflow_flag});
      drs_seq_model_inst.access(1'b0, ADDR_HIGH_WORD, 32'h00000000, q);
      chk("high word", {8'h00, e[47:24]}, q);
      drs_seq_model_inst.access(1'b0, ADDR_LOW_WORD, 32'h00000000, q);
      chk("low word", {8'h00, e[23:0]}, q);
      if (e[48])
        drs_seq_model_inst.access(1'b1, ADDR_STATUS, 32'h00000002, q);
    end
    // Normalize is refused here, and unmapped places store nothing and read back as zero.
    drs_seq_model_inst.access(1'b1, ADDR_COMMAND, 32'h00004005, q);
    drs_seq_model_inst.access(1'b0, ADDR_STATUS, 32'h00000000, q);
    chk("normalize status", 32'h00000004, q & 32'h00000005);
    drs_seq_model_inst.access(1'b0, ADDR_HIGH_WORD, 32'h00000000, q);
    chk("normalize high", {8'h00, e[47:24]}, q);
    drs_seq_model_inst.access(1'b1, 3'h7, 32'h00FFFFFF, q);
    drs_seq_model_inst.access(1'b0, 3'h7, 32'h00000000, q);
    chk("unmapped", 32'h00000000, q);
    conclude();
  end
endmodule : drs_shifter_bench
